/* core/dbm_pkg.sv */
// Package for the dual bridge motor control block: drive codes, bridge structs, timing.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// Functional notes
// [RULE1] All inputs low turns every output off.
// [RULE2] Host sequences four or eight stepper states.
// [RULE3] Input pair gives forward, reverse or brake.
// [RULE4] Both inputs low floats that bridge.
// [RULE5] Fast decay alternates drive and off.
// [RULE6] Slow decay alternates drive and brake.
// [RULE7] Paralleled use drives both pairs identically.
// [RULE8] High is source on, low sink.
// [RULE9] Sleep after inputs low beyond timeout.
// [RULE10] Source overcurrent past filter time faults.
// [RULE11] Sink overvoltage past filter time faults.
// [RULE12] Fault turns off whole bridge at once.
// [RULE13] Ignore bridge inputs for retry period.
// [RULE14] Each bridge has independent fault timing.
// [RULE15] Thermal trip disables outputs until cooled.
// [RULE16] Low supply lockout holds outputs off.
package dbm_pkg;

	localparam int CLK_HZ         = 100_000_000;
	localparam int SLEEP_TIME_US  = 1000;
	localparam int FILTER_TIME_NS = 2000;
	localparam int RETRY_TIME_US  = 2000;

	// Filter is a least time: round up.
	localparam int FILTER_CYC = (FILTER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SLEEP_CYC  = SLEEP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int RETRY_CYC  = RETRY_TIME_US * (CLK_HZ / 1_000_000);

	localparam int CNT_W = 24;

	// Per-output drive state: source on, sink on, or both off.
	typedef enum logic [1:0] {
		DBM_OFF,
		DBM_SRC,
		DBM_SNK
	} dbm_drive_t;

	// Pin-level view of one half-bridge output.
	typedef struct packed {
		logic src_on;
		logic snk_on;
	} dbm_half_t;

	typedef struct packed {
		dbm_half_t p;
		dbm_half_t n;
	} dbm_bridge_t;

	localparam dbm_half_t HALF_OFF = 2'h0;

endpackage

/* core/dbm_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes the inputs are asynchronous to clk.
module dbm_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;
endmodule

/* core/dbm_bridge_guard.sv */
// Overcurrent guard and retry timer for one full bridge.
// Assumes the sense inputs are already synchronised to clk.
module dbm_bridge_guard
	import dbm_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Drive commands as applied to this bridge
	input  wire logic src_p_on,
	input  wire logic src_n_on,
	input  wire logic snk_p_on,
	input  wire logic snk_n_on,
	// Analog comparators
	input  wire logic src_p_over,
	input  wire logic src_n_over,
	input  wire logic snk_p_over,
	input  wire logic snk_n_over,
	// Status
	output logic      blocked
);
	import dbm_pkg::*;

	typedef enum logic [1:0] {
		GRD_RUN,
		GRD_HOLD
	} dbm_grd_t;

	dbm_grd_t         st_r, st_nxt;
	logic [CNT_W-1:0] filt_r, filt_nxt;
	logic [CNT_W-1:0] hold_r, hold_nxt;
	logic             over;

	// Current is only judged while the monitored driver is on. [RULE10] [RULE11]
	assign over = (src_p_on && src_p_over) || (src_n_on && src_n_over)
		|| (snk_p_on && snk_p_over) || (snk_n_on && snk_n_over);

	always_comb begin
		st_nxt   = st_r;
		filt_nxt = filt_r;
		hold_nxt = hold_r;
		case (st_r)
			GRD_RUN: begin
				if (!over) begin
					filt_nxt = '0;
				end else if (filt_r >= CNT_W'(FILTER_CYC)) begin
					st_nxt   = GRD_HOLD; // [RULE10] [RULE11]
					hold_nxt = '0;
					filt_nxt = '0;
				end else begin
					filt_nxt = filt_r + 1'b1;
				end
			end
			GRD_HOLD: begin
				// Retry only after the full ignore period. [RULE13]
				if (hold_r >= CNT_W'(RETRY_CYC - 1)) begin
					st_nxt = GRD_RUN;
				end else begin
					hold_nxt = hold_r + 1'b1;
				end
			end
			default: st_nxt = GRD_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r   <= GRD_RUN;
			filt_r <= '0;
			hold_r <= '0;
		end else begin
			st_r   <= st_nxt;
			filt_r <= filt_nxt;
			hold_r <= hold_nxt;
		end
	end

	// Combinational so the bridge drops in the very cycle of the trip. [RULE12]
	assign blocked = (st_r == GRD_HOLD) || (st_r == GRD_RUN && over
		&& filt_r >= CNT_W'(FILTER_CYC));

	hold_len_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		$rose(st_r == GRD_HOLD) |-> (st_r == GRD_HOLD) [*8])
		else $error("Bridge left hold too early.");

	trip_block_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
		(st_r == GRD_RUN && st_nxt == GRD_HOLD) |-> blocked)
		else $error("Trip did not block the bridge.");

	no_glitch_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		!over |=> st_r == GRD_RUN || $past(st_r) == GRD_HOLD)
		else $error("Fault without overcurrent.");
endmodule

/* core/dbm_core.sv */
// Top of the dual bridge motor control block: input decode, sleep, protection.
// Assumes control pins and analog comparator flags arrive asynchronously.
module dbm_core
	import dbm_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Host control pins
	input  wire logic bridge_a_ctrl_p,
	input  wire logic bridge_a_ctrl_n,
	input  wire logic bridge_b_ctrl_p,
	input  wire logic bridge_b_ctrl_n,
	// Comparator flags: source overcurrent, sink overvoltage
	input  wire logic [3:0] src_over,
	input  wire logic [3:0] snk_over,
	// Thermal and supply monitors
	input  wire logic thermal_trip_point,
	input  wire logic low_supply_lockout,
	// Driver gate controls, output order a_p, a_n, b_p, b_n
	output logic [3:0] src_on,
	output logic [3:0] snk_on,
	// Status
	output logic asleep,
	output logic [1:0] bridge_fault
);
	import dbm_pkg::*;

	logic [3:0]       ctrl_s;
	logic [3:0]       src_over_s, snk_over_s;
	logic [1:0]       mon_s;
	logic [CNT_W-1:0] idle_r, idle_nxt;
	logic             sleep_r, sleep_nxt;
	logic             hot_r, hot_nxt;
	logic [3:0]       src_r, src_nxt;
	logic [3:0]       snk_r, snk_nxt;
	logic [1:0]       blocked;
	logic             all_low;
	logic             kill_all;
	logic             over_a;
	logic             over_b;

	dbm_sync #(.W(4)) u_sync_ctrl (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({bridge_b_ctrl_n, bridge_b_ctrl_p, bridge_a_ctrl_n, bridge_a_ctrl_p}),
		.q       (ctrl_s)
	);

	dbm_sync #(.W(10)) u_sync_mon (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({src_over, snk_over, thermal_trip_point, low_supply_lockout}),
		.q       ({src_over_s, snk_over_s, mon_s})
	);

	// Decode one input pair into a half-bridge pair. [RULE3] [RULE8]
	function automatic dbm_bridge_t decode(input logic p, input logic n);
		dbm_bridge_t b;
		b = '0;
		case ({p, n})
			2'h2: begin
				b.p.src_on = 1'b1;
				b.n.snk_on = 1'b1;
			end
			2'h1: begin
				b.p.snk_on = 1'b1;
				b.n.src_on = 1'b1;
			end
			// Brake, also slow decay in external PWM. [RULE6]
			2'h3: begin
				b.p.snk_on = 1'b1;
				b.n.snk_on = 1'b1;
			end
			// Coast, fast decay, and the idle bridge of a half step. [RULE2] [RULE4] [RULE5]
			default: b = {HALF_OFF, HALF_OFF};
		endcase
		return b;
	endfunction

	assign all_low = (ctrl_s == 4'h0);

	// Thermal shutdown is a registered copy of the monitor level; the monitor's own hysteresis releases it. [RULE15]
	// Supply lockout is a level and overrides everything. [RULE16]
	assign kill_all = hot_r || mon_s[0];

	always_comb begin
		dbm_bridge_t ba;
		dbm_bridge_t bb;
		ba        = decode(ctrl_s[0], ctrl_s[1]);
		bb        = decode(ctrl_s[2], ctrl_s[3]);
		idle_nxt  = idle_r;
		sleep_nxt = sleep_r;
		hot_nxt   = mon_s[1];
		// Sleep counter: any high input wakes the device at once. [RULE9]
		if (!all_low) begin
			idle_nxt  = '0;
			sleep_nxt = 1'b0;
		end else if (idle_r >= CNT_W'(SLEEP_CYC)) begin
			sleep_nxt = 1'b1;
		end else begin
			idle_nxt = idle_r + 1'b1;
		end
		src_nxt = {bb.n.src_on, bb.p.src_on, ba.n.src_on, ba.p.src_on};
		snk_nxt = {bb.n.snk_on, bb.p.snk_on, ba.n.snk_on, ba.p.snk_on};
		// Each bridge is blocked only by its own guard. [RULE12] [RULE14]
		if (blocked[0]) begin
			src_nxt[1:0] = 2'h0;
			snk_nxt[1:0] = 2'h0;
		end
		if (blocked[1]) begin
			src_nxt[3:2] = 2'h0;
			snk_nxt[3:2] = 2'h0;
		end
		if (kill_all || all_low) begin // [RULE1] [RULE15] [RULE16]
			src_nxt = 4'h0;
			snk_nxt = 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_r  <= '0;
			sleep_r <= 1'b0;
			hot_r   <= 1'b0;
			src_r   <= 4'h0;
			snk_r   <= 4'h0;
		end else begin
			idle_r  <= idle_nxt;
			sleep_r <= sleep_nxt;
			hot_r   <= hot_nxt;
			src_r   <= src_nxt;
			snk_r   <= snk_nxt;
		end
	end

	// A registered drive plus a combinational trip gate: the bridge falls in
	// the trip cycle itself rather than one cycle late.
	dbm_bridge_guard u_guard_a (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.src_p_on   (src_r[0]),
		.src_n_on   (src_r[1]),
		.snk_p_on   (snk_r[0]),
		.snk_n_on   (snk_r[1]),
		.src_p_over (src_over_s[0]),
		.src_n_over (src_over_s[1]),
		.snk_p_over (snk_over_s[0]),
		.snk_n_over (snk_over_s[1]),
		.blocked    (blocked[0])
	);

	dbm_bridge_guard u_guard_b (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.src_p_on   (src_r[2]),
		.src_n_on   (src_r[3]),
		.snk_p_on   (snk_r[2]),
		.snk_n_on   (snk_r[3]),
		.src_p_over (src_over_s[2]),
		.src_n_over (src_over_s[3]),
		.snk_p_over (snk_over_s[2]),
		.snk_n_over (snk_over_s[3]),
		.blocked    (blocked[1])
	);

	assign src_on[1:0]  = blocked[0] ? 2'h0 : src_r[1:0];
	assign snk_on[1:0]  = blocked[0] ? 2'h0 : snk_r[1:0];
	assign src_on[3:2]  = blocked[1] ? 2'h0 : src_r[3:2];
	assign snk_on[3:2]  = blocked[1] ? 2'h0 : snk_r[3:2];
	assign asleep       = sleep_r;
	assign bridge_fault = blocked;

	sequence fwd_cmd_s;
		ctrl_s[1:0] == 2'h1 && !kill_all && !blocked[0];
	endsequence

	all_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		all_low |=> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Outputs driven with all inputs low.");

	fwd_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		fwd_cmd_s ##1 !blocked[0] |-> src_on[1:0] == 2'h1 && snk_on[1:0] == 2'h2)
		else $error("Forward decode wrong on bridge a.");

	brake_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		ctrl_s[3:2] == 2'h3 && !kill_all ##1 !blocked[1] |-> snk_on[3:2] == 2'h3
		&& src_on[3:2] == 2'h0)
		else $error("Brake decode wrong on bridge b.");

	coast_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		ctrl_s[1:0] == 2'h0 |=> src_on[1:0] == 2'h0 && snk_on[1:0] == 2'h0)
		else $error("Bridge a not floating on coast.");

	no_shoot_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		(src_on & snk_on) == 4'h0)
		else $error("Source and sink on together.");

	sleep_wait_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		$rose(all_low) |-> !asleep [*8])
		else $error("Sleep entered too soon.");

	wake_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		!all_low |=> !asleep)
		else $error("Asleep while an input is high.");

	fault_iso_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
		blocked[0] && !blocked[1] && !kill_all && ctrl_s[3:2] == 2'h1
		&& $past(ctrl_s[3:2]) == 2'h1 && !$past(kill_all) && !$past(all_low)
		&& !$past(blocked[1]) |-> src_on[2] && snk_on[3])
		else $error("Fault on bridge a disturbed bridge b.");

	lock_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
		mon_s[0] |=> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Driver on during supply lockout.");

	hot_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
		hot_r |=> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Driver on during thermal shutdown.");

	// The drive register reloads from the decode only after the shutdown source
	// has gone, so the first cycle after release must still be off.
	hot_exit_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
		$fell(hot_r) |-> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Driver on as thermal shutdown ended.");

	lock_exit_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
		$fell(mon_s[0]) |-> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Driver on as supply lockout ended.");

	// The remaining pair decodes, so that a swapped pin or output index on
	// either bridge cannot go unnoticed.
	sequence rev_a_cmd_s;
		ctrl_s[1:0] == 2'h2 && !kill_all && !blocked[0];
	endsequence

	sequence fwd_b_cmd_s;
		ctrl_s[3:2] == 2'h1 && !kill_all && !blocked[1];
	endsequence

	sequence rev_b_cmd_s;
		ctrl_s[3:2] == 2'h2 && !kill_all && !blocked[1];
	endsequence

	sequence brake_a_cmd_s;
		ctrl_s[1:0] == 2'h3 && !kill_all && !blocked[0];
	endsequence

	a_rev_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		rev_a_cmd_s ##1 !blocked[0] |-> src_on[1:0] == 2'h2 && snk_on[1:0] == 2'h1)
		else $error("Reverse decode wrong on bridge a.");

	b_fwd_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		fwd_b_cmd_s ##1 !blocked[1] |-> src_on[3:2] == 2'h1 && snk_on[3:2] == 2'h2)
		else $error("Forward decode wrong on bridge b.");

	b_rev_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		rev_b_cmd_s ##1 !blocked[1] |-> src_on[3:2] == 2'h2 && snk_on[3:2] == 2'h1)
		else $error("Reverse decode wrong on bridge b.");

	a_brake_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		brake_a_cmd_s ##1 !blocked[0] |-> snk_on[1:0] == 2'h3 && src_on[1:0] == 2'h0)
		else $error("Brake decode wrong on bridge a.");

	b_coast_dec_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4] [RULE5]
		ctrl_s[3:2] == 2'h0 |=> src_on[3:2] == 2'h0 && snk_on[3:2] == 2'h0)
		else $error("Bridge b not floating on coast.");

	// Sleep is only a status here: the drive is already off when it is entered.
	sleep_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1] [RULE9]
		asleep |-> src_on == 4'h0 && snk_on == 4'h0)
		else $error("Driver on while asleep.");

	sleep_time_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		$rose(asleep) |-> $past(all_low) && idle_r == CNT_W'(SLEEP_CYC))
		else $error("Sleep entered before the idle time ran out.");

	// Raw comparator activity per bridge, used only by the trip checks below.
	// They look at the comparators alone, not at the guard's own view.
	assign over_a = |{src_over_s[1:0], snk_over_s[1:0]};
	assign over_b = |{src_over_s[3:2], snk_over_s[3:2]};

	// A trip needs the comparator to have stood through the filter, so a single
	// noisy sample must never block a bridge.
	a_trip_cause_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10] [RULE11]
		$rose(blocked[0]) |-> over_a && $past(over_a, 8))
		else $error("Bridge a tripped without a lasting overcurrent.");

	b_trip_cause_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10] [RULE11]
		$rose(blocked[1]) |-> over_b && $past(over_b, 8))
		else $error("Bridge b tripped without a lasting overcurrent.");

	a_trip_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
		blocked[0] |-> src_on[1:0] == 2'h0 && snk_on[1:0] == 2'h0)
		else $error("Bridge a driven while blocked.");

	b_trip_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
		blocked[1] |-> src_on[3:2] == 2'h0 && snk_on[3:2] == 2'h0)
		else $error("Bridge b driven while blocked.");

	// While a bridge holds, the drive register must not follow its pins.
	a_hold_ign_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		blocked[0] && $past(blocked[0]) |-> src_r[1:0] == 2'h0 && snk_r[1:0] == 2'h0)
		else $error("Bridge a followed its pins during hold.");

	b_hold_ign_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		blocked[1] && $past(blocked[1]) |-> src_r[3:2] == 2'h0 && snk_r[3:2] == 2'h0)
		else $error("Bridge b followed its pins during hold.");
endmodule

/* testbench/dbm_host_model.sv */
// Host controller model: drives the four control pins of the block.
// Assumes a free-running clk; pins change only by nonblocking assignment at posedge.
module dbm_host_model (
	// Clock
	input  wire logic       clk,
	// Control pins, order a_p, a_n, b_p, b_n
	output logic      [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Even entries are the four full-step states, odd ones leave one bridge idle.
	localparam logic [3:0] HALF [8] = '{4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};
	initial pins = 4'h0;
	task automatic drive(input logic [3:0] v);
		@(posedge clk);
		pins <= v;
	endtask
	function automatic logic [3:0] half_step(input int i);
		return HALF[i % 8];
	endfunction
	function automatic logic [1:0] decay(input logic slow);
		return slow ? 2'h3 : 2'h0;
	endfunction
	function automatic logic [3:0] para(input logic [1:0] pr);
		return {pr, pr};
	endfunction
endmodule

/* testbench/tb.sv */
// Self-checking bench for the dual bridge motor control block.
// Assumes the package counts; the long sleep wait sets the run length.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dbm_pkg::*;
	typedef struct packed {
		logic [3:0] src;
		logic [3:0] snk;
		logic [1:0] flt;
		logic       slp;
	} dbm_note_t;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       therm = 1'b0;
	logic       lock = 1'b0;
	logic [3:0] pins;
	logic [3:0] src_over = 4'h0;
	logic [3:0] snk_over = 4'h0;
	logic [3:0] src_on;
	logic [3:0] snk_on;
	logic       asleep;
	logic [1:0] bridge_fault;
	logic [3:0] cur = 4'h0;
	logic [1:0] blk = 2'h0;
	logic [3:0] rv;
	dbm_note_t  e_w;
	dbm_note_t  notes [$];
	int         num_errors = 0;
	int         n_compared = 0;
	int         cyc = 0;
	dbm_host_model dbm_host_model_inst (.clk(clk), .pins(pins));
	dbm_core dbm_core_inst (
		.clk(clk), .sys_rst(sys_rst),
		.bridge_a_ctrl_p(pins[3]), .bridge_a_ctrl_n(pins[2]),
		.bridge_b_ctrl_p(pins[1]), .bridge_b_ctrl_n(pins[0]),
		.src_over(src_over), .snk_over(snk_over),
		.thermal_trip_point(therm), .low_supply_lockout(lock),
		.src_on(src_on), .snk_on(snk_on), .asleep(asleep), .bridge_fault(bridge_fault)
	);
	always #5 clk = ~clk;
	// Output bits run a_p, a_n, b_p, b_n from bit 0; a blocked bridge shows off.
	function automatic dbm_note_t expv(input logic [3:0] p, input logic [1:0] b,
		input logic off, input logic s);
		dbm_note_t e;
		logic [3:0] m;
		m = {{2{~b[1]}}, {2{~b[0]}}} & {4{~off}};
		e.src = {p[0] & ~p[1], p[1] & ~p[0], p[2] & ~p[3], p[3] & ~p[2]} & m;
		e.snk = {p[1], p[0], p[3], p[2]} & m;
		e.flt = b;
		e.slp = s;
		return e;
	endfunction
	task automatic note(input logic s);
		notes.push_back(expv(cur, blk, therm | lock, s));
	endtask
	task automatic go(input logic [3:0] v, input int n, input logic s);
		dbm_host_model_inst.drive(v);
		cur = v;
		repeat (n) @(posedge clk);
		note(s);
	endtask
	task automatic complete_run();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		while (notes.size() > 0) begin
			e_w = notes.pop_front();
			n_compared++;
			if ({src_on, snk_on, bridge_fault, asleep} !== e_w) begin
				num_errors++;
				$display("[ERR] outputs expected %h seen %h", e_w,
					{src_on, snk_on, bridge_fault, asleep});
			end
		end
	end
	// The sleep wait alone is about 100k cycles; everything else adds under 1k.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 110000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(96897));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		note(1'b0);
		for (int i = 0; i < 16; i++) go(i[3:0], 4, 1'b0);
		for (int i = 0; i < 8; i++) go(dbm_host_model_inst.half_step(i), 4, 1'b0);
		for (int k = 0; k < 8; k++) go(dbm_host_model_inst.para(k[0] ?
			dbm_host_model_inst.decay(k[1]) : (k[2] ? 2'h1 : 2'h2)), 4, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rv = 4'($urandom);
			go(rv, 4, 1'b0);
		end
		go(4'h9, 4, 1'b0);
		therm <= 1'b1;
		repeat (6) @(posedge clk);
		note(1'b0);
		therm <= 1'b0;
		lock <= 1'b1;
		repeat (6) @(posedge clk);
		note(1'b0);
		lock <= 1'b0;
		repeat (6) @(posedge clk);
		note(1'b0);
		go(4'h0, SLEEP_CYC - 8, 1'b0);
		repeat (16) @(posedge clk);
		note(1'b1);
		go(4'hA, 4, 1'b0);
		src_over <= 4'h1;
		repeat (FILTER_CYC - 10) @(posedge clk);
		src_over <= 4'h0;
		repeat (6) @(posedge clk);
		note(1'b0);
		src_over <= 4'h1;
		repeat (FILTER_CYC + 6) @(posedge clk);
		blk = 2'h1;
		note(1'b0);
		src_over <= 4'h0;
		go(4'h6, 8, 1'b0);
		snk_over <= 4'h8;
		repeat (FILTER_CYC + 6) @(posedge clk);
		blk = 2'h3;
		note(1'b0);
		snk_over <= 4'h0;
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
